// file: inc/mci_pkg.sv
// Purpose: Shared constants of the monitor configuration and fault status block
// Assumes: 250 MHz core clock
// Notes:   Register offsets are the byte addresses seen by the serial engine
package mci_pkg;
    // Register map
    localparam logic [7:0] MCI_OFS_CONFIG = 8'h40;
    localparam logic [7:0] MCI_OFS_FAULT1 = 8'h41;
    // Reset values
    localparam logic [7:0] MCI_CONFIG_RST = 8'h08;
    localparam logic [7:0] MCI_FAULT1_RST = 8'h00;
    localparam logic [7:0] MCI_RDATA_RST  = 8'h00;
    // Configuration bit positions
    localparam int MCI_CFG_RUN     = 0;
    localparam int MCI_CFG_INT_EN  = 1;
    localparam int MCI_CFG_INT_CLR = 3;
    localparam int MCI_CFG_RST_REQ = 4;
    localparam int MCI_CFG_CHS_CLR = 6;
    localparam int MCI_CFG_INIT    = 7;
    // Fault bit positions
    localparam int MCI_FLT_TEMP    = 4;
    localparam int MCI_FLT_RSVD    = 5;
    // Pulse timing
    localparam int MCI_CLK_KHZ      = 250000;
    localparam int MCI_PULSE_MS     = 20;
    localparam int MCI_PULSE_CYCLES = MCI_PULSE_MS * MCI_CLK_KHZ;
endpackage

// file: rtl/mci_pulse_timer.sv
// Purpose: Timed pulse generator, busy for a fixed number of clock cycles
// Assumes: start may be held high, ignored while busy
// Notes:   busy and idle come straight from flip-flops
`timescale 1ns/10ps
module mci_pulse_timer #(
    parameter int CYCLES = 5000000
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    // Control
    input  wire logic start_in,
    // Status
    output logic      busy_out,
    output logic      idle_out,
    output logic      done_out
);
    logic [31:0] count_r;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_r  <= 32'h0000_0000;
            busy_out <= 1'b0;
            idle_out <= 1'b1;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (!busy_out && start_in) begin
                count_r  <= 32'(CYCLES - 1);
                busy_out <= 1'b1;
                idle_out <= 1'b0;
            end else if (busy_out) begin
                if (count_r == 32'h0000_0000) begin
                    busy_out <= 1'b0;
                    idle_out <= 1'b1;
                    done_out <= 1'b1;
                end else begin
                    count_r <= count_r - 32'h0000_0001;
                end
            end
        end
    end
endmodule

// file: rtl/mci_config_status.sv
// Purpose: Configuration register, primary fault flags and interrupt output
// Assumes: Serial engine presents decoded single-cycle register reads and writes
// Notes:   Mask, second status and temperature mode logic sit outside this block
`timescale 1ns/10ps
// Behaviour
// - run bit scans, zero means standby
// - clearing run never releases interrupt pin
// - run starts scanning and limit comparison
// - interrupt enable gates output, resets zero
// - interrupt clear releases pin, keeps flags
// - interrupt clear suspends monitoring, resets one
// - reset request drives 20 ms low pulse
// - reset request clears when pulse starts
// - reset pulse only when permit bit set
// - chassis clear pulses line, then self-clears
// - chassis line held low 20 ms
// - init restores defaults except analog, values
// - init bit clears itself after acting
// - supply faults set bits zero to three
// - temperature fault sets bit four
// - fan faults set bits six, seven
// - reading flags clears them to default
// - mask bit blocks its flag from interrupt
module mci_config_status import mci_pkg::*; #(
    parameter int PULSE_CYCLES = MCI_PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    // Register access from serial engine
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    // Fault events from comparators and temperature mode logic
    input  wire logic [3:0] supply_fault_in,
    input  wire logic       temp_fault_in,
    input  wire logic [1:0] fan_fault_in,
    // Masks and pending flags from neighbouring registers
    input  wire logic [7:0] fault_mask_in,
    input  wire logic       reset_permit_in,
    input  wire logic       other_irq_in,
    // Monitoring control
    output logic            scan_enable_out,
    output logic            init_pulse_out,
    // Device pins
    output logic            int_n_out,
    output logic            reset_n_out,
    input  wire logic       chassis_intrusion_line_in,
    output logic            chassis_intrusion_line_out,
    output logic            chassis_intrusion_line_oe_out
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] config_r;
    logic [7:0] fault_r;
    logic [7:0] fault_nxt;
    logic [7:0] fault_events;
    logic       monitor_on;
    logic       cfg_wr;
    logic       flt_rd;
    logic       init_wr;
    logic       rst_start;
    logic       chs_start;
    logic       rst_busy;
    logic       rst_idle;
    logic       chs_done;
    logic [31:0] chs_len_r;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    assign cfg_wr     = reg_wr_in && addr_hit(reg_addr_in, MCI_OFS_CONFIG);
    assign flt_rd     = reg_rd_in && addr_hit(reg_addr_in, MCI_OFS_FAULT1);
    assign init_wr    = cfg_wr && reg_wdata_in[MCI_CFG_INIT];
    assign monitor_on = config_r[MCI_CFG_RUN] && !config_r[MCI_CFG_INT_CLR];
    assign rst_start  = config_r[MCI_CFG_RST_REQ] && reset_permit_in && rst_idle;
    // Done blocks a restart while the request bit is still being cleared
    assign chs_start  = config_r[MCI_CFG_CHS_CLR] && !chs_done;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            config_r <= MCI_CONFIG_RST;
        end else if (init_wr) begin
            config_r <= MCI_CONFIG_RST;
        end else if (cfg_wr) begin
            config_r                <= reg_wdata_in;
            config_r[MCI_CFG_INIT]  <= 1'b0;
        end else begin
            if (rst_start) begin
                config_r[MCI_CFG_RST_REQ] <= 1'b0;
            end
            if (chs_done) begin
                config_r[MCI_CFG_CHS_CLR] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Primary fault flags, set wins over read clear
    always_comb begin
        fault_events                = 8'h00;
        fault_events[3:0]           = supply_fault_in;
        fault_events[MCI_FLT_TEMP]  = temp_fault_in;
        fault_events[7:6]           = fan_fault_in;
        if (!monitor_on) begin
            fault_events = 8'h00;
        end
        fault_nxt = (flt_rd ? MCI_FAULT1_RST : fault_r) | fault_events;
        fault_nxt[MCI_FLT_RSVD] = 1'b0;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault_r <= MCI_FAULT1_RST;
        end else if (init_wr) begin
            fault_r <= MCI_FAULT1_RST;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= MCI_RDATA_RST;
        end else if (reg_rd_in) begin
            if (addr_hit(reg_addr_in, MCI_OFS_CONFIG)) begin
                reg_rdata_out <= config_r;
            end else if (addr_hit(reg_addr_in, MCI_OFS_FAULT1)) begin
                reg_rdata_out <= fault_r;
            end else begin
                reg_rdata_out <= MCI_RDATA_RST;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin, scan control and init strobe
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            int_n_out <= 1'b1;
        end else begin
            int_n_out <= !(config_r[MCI_CFG_INT_EN] && !config_r[MCI_CFG_INT_CLR]
                        && ((|(fault_r & ~fault_mask_in)) || other_irq_in));
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scan_enable_out <= 1'b0;
            init_pulse_out  <= 1'b0;
        end else begin
            scan_enable_out <= monitor_on;
            init_pulse_out  <= init_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset and chassis pulse timers
    mci_pulse_timer #(.CYCLES(PULSE_CYCLES)) u_rst_timer (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .start_in   (rst_start),
        .busy_out   (rst_busy),
        .idle_out   (rst_idle),
        .done_out   ()
    );
    assign reset_n_out = rst_idle;

    mci_pulse_timer #(.CYCLES(PULSE_CYCLES)) u_chs_timer (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .start_in   (chs_start),
        .busy_out   (chassis_intrusion_line_oe_out),
        .idle_out   (),
        .done_out   (chs_done)
    );
    assign chassis_intrusion_line_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Assertion helpers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            chs_len_r <= 32'h0000_0000;
        end else if (chassis_intrusion_line_oe_out) begin
            chs_len_r <= chs_len_r + 32'h0000_0001;
        end else begin
            chs_len_r <= 32'h0000_0000;
        end
    end

    a_scan_follows_run: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (config_r[MCI_CFG_RUN] && !config_r[MCI_CFG_INT_CLR]) |=> scan_enable_out)
        else $error("scan not enabled while running");
    a_standby_no_scan: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        config_r[MCI_CFG_INT_CLR] |=> !scan_enable_out
        ##0 ($stable(fault_r) || $past(flt_rd) || $past(init_wr)))
        else $error("monitoring during interrupt clear");
    a_int_gated_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !config_r[MCI_CFG_INT_EN] |=> int_n_out)
        else $error("interrupt asserted while disabled");
    a_int_clear_pin: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (config_r[MCI_CFG_INT_CLR] && !flt_rd && !init_wr) |=> int_n_out && fault_r == $past(fault_r))
        else $error("interrupt clear failed");
    a_int_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (config_r[MCI_CFG_INT_EN] && !config_r[MCI_CFG_INT_CLR]
         && |(fault_r & ~fault_mask_in)) |=> !int_n_out)
        else $error("unmasked flag did not raise interrupt");
    a_rst_self_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(reset_n_out) |-> !config_r[MCI_CFG_RST_REQ] || $past(cfg_wr))
        else $error("reset request not cleared");
    a_rst_permit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(reset_n_out) |-> $past(reset_permit_in) && rst_busy)
        else $error("reset pulse without permit");
    a_chs_hold_len: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(chassis_intrusion_line_oe_out) |-> chs_len_r == 32'(PULSE_CYCLES))
        else $error("chassis pulse length wrong");
    a_flag_read_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (flt_rd && !init_wr) |=> fault_r == $past(fault_events))
        else $error("read did not clear flags");
    a_init_restore: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        init_wr |=> config_r == MCI_CONFIG_RST && fault_r == MCI_FAULT1_RST
        ##1 (!init_pulse_out || $past(init_wr)))
        else $error("init did not restore defaults");
endmodule

// file: dv/mci_chassis_latch.sv
// Purpose: External chassis intrusion latch on the open-drain chassis line
// Assumes: Latch drives the line high once set; only the monitor pulls it low
// Notes:   Latch clears only after a full-length low pulse, never on a short one
`timescale 1ns/10ps
module mci_chassis_latch #(
    parameter int MIN_LOW = 16
) (
    // Clock and event
    input  wire logic clk_in,
    input  wire logic intrude_in,
    // Monitor side of the line
    input  wire logic oe_in,
    input  wire logic drv_in,
    output logic      line_out
);
    logic latched_r;
    int   low_cnt;
    wire  pull_low = oe_in && !drv_in;
    assign line_out = pull_low ? 1'b0 : latched_r;
    initial latched_r = 1'b0;
    initial low_cnt = 0;
    always @(posedge clk_in) begin
        low_cnt <= pull_low ? low_cnt + 1 : 0;
        if (intrude_in)
            latched_r <= 1'b1;
        else if (!pull_low && low_cnt >= MIN_LOW)
            latched_r <= 1'b0;
    end
endmodule

// file: dv/monitor_config_irq_status_tb.sv
// Purpose: Self-checking bench for configuration, fault flags and pins
// Assumes: Pulse length shortened to 16 cycles
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module monitor_config_irq_status_tb;
    import mci_pkg::*;
    localparam int PC = 16;
    logic clk_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, temp_fault_in = 0;
    logic reset_permit_in = 0, other_irq_in = 0, intr = 0;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, fault_mask_in = 8'h00, reg_rdata_out;
    logic [3:0] supply_fault_in = 4'h0;
    logic [1:0] fan_fault_in = 2'h0;
    logic scan_enable_out, init_pulse_out, int_n_out, reset_n_out, chs_out, chs_oe, chs_line;
    int   n_mismatch = 0, checks = 0, n;
    always #2 clk_in = ~clk_in;
    mci_config_status #(.PULSE_CYCLES(PC)) mci_config_status_i (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .supply_fault_in(supply_fault_in), .temp_fault_in(temp_fault_in),
        .fan_fault_in(fan_fault_in), .fault_mask_in(fault_mask_in),
        .reset_permit_in(reset_permit_in), .other_irq_in(other_irq_in),
        .scan_enable_out(scan_enable_out), .init_pulse_out(init_pulse_out),
        .int_n_out(int_n_out), .reset_n_out(reset_n_out),
        .chassis_intrusion_line_in(chs_line), .chassis_intrusion_line_out(chs_out),
        .chassis_intrusion_line_oe_out(chs_oe));
    mci_chassis_latch #(.MIN_LOW(PC)) mci_chassis_latch_i (.clk_in(clk_in),
        .intrude_in(intr), .oe_in(chs_oe), .drv_in(chs_out), .line_out(chs_line));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1;
        cyc(1);
        reg_wr_in = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        cyc(1);
        reg_addr_in = a;
        reg_rd_in = 1;
        cyc(1);
        reg_rd_in = 0;
        cmp8("read data", exp, reg_rdata_out);
    endtask
    task automatic ev(input logic [7:0] b);
        {fan_fault_in, temp_fault_in, supply_fault_in} = {b[7:6], b[4], b[3:0]};
        cyc(1);
        {fan_fault_in, temp_fault_in, supply_fault_in} = 7'h00;
        cyc(1);
    endtask
    function automatic logic lv(input bit c);
        return c ? chs_oe : !reset_n_out;
    endfunction
    // Measures a pulse in cycles; a pulse that never starts ends the run
    task automatic pl(input bit c);
        int i;
        for (i = 0; i < 20 && lv(c) !== 1'b1; i++)
            cyc(1);
        if (i == 20) begin
            n_mismatch++;
            test_done();
        end
        n = 0;
        while (lv(c) === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        cmp8("pulse cycles", 8'(PC), 8'(n));
    endtask
    initial begin
        cyc(8);
        reset_n_in = 1;
        rd(MCI_OFS_CONFIG, MCI_CONFIG_RST);
        rd(MCI_OFS_FAULT1, MCI_FAULT1_RST);
        rd(8'h50, 8'h00);
        cmp8("pins", 8'h06, {int_n_out, reset_n_out, scan_enable_out});
        wr(8'h40, 8'h0B);
        ev(8'h01);
        rd(8'h41, 8'h00);
        cmp8("scan", 8'h00, scan_enable_out);
        $display("test reset and suspend done");
        wr(8'h40, 8'h03);
        cyc(1);
        cmp8("scan", 8'h01, scan_enable_out);
        for (int b = 0; b < 8; b++) begin
            if (b == 5)
                continue;
            ev(8'h01 << b);
            cmp8("interrupt", 8'h00, int_n_out);
            rd(8'h41, 8'h01 << b);
            rd(8'h41, 8'h00);
            cmp8("interrupt", 8'h01, int_n_out);
        end
        fault_mask_in = 8'h01;
        ev(8'h01);
        cmp8("interrupt", 8'h01, int_n_out);
        rd(8'h41, 8'h01);
        fault_mask_in = 8'h00;
        other_irq_in = 1;
        cyc(2);
        cmp8("interrupt", 8'h00, int_n_out);
        other_irq_in = 0;
        ev(8'h02);
        wr(8'h40, 8'h02);
        cyc(2);
        cmp8("interrupt", 8'h00, int_n_out);
        wr(8'h40, 8'h0A);
        cyc(2);
        cmp8("interrupt", 8'h01, int_n_out);
        rd(8'h41, 8'h02);
        wr(8'h40, 8'h01);
        ev(8'h04);
        cmp8("interrupt", 8'h01, int_n_out);
        rd(8'h41, 8'h04);
        $display("test flags and interrupt done");
        wr(8'h40, 8'h11);
        cyc(4);
        cmp8("reset pin", 8'h01, reset_n_out);
        rd(8'h40, 8'h11);
        reset_permit_in = 1;
        pl(0);
        rd(8'h40, 8'h01);
        intr = 1;
        cyc(1);
        intr = 0;
        cmp8("chassis line", 8'h01, chs_line);
        wr(8'h40, 8'h41);
        pl(1);
        cyc(2);
        cmp8("chassis line", 8'h00, chs_line);
        cmp8("chassis drive", 8'h00, chs_oe);
        rd(8'h40, 8'h01);
        $display("test pulses done");
        ev(8'h08);
        wr(8'h40, 8'h83);
        cmp8("init pulse", 8'h01, init_pulse_out);
        rd(8'h40, MCI_CONFIG_RST);
        rd(8'h41, MCI_FAULT1_RST);
        $display("test init done");
        test_done();
    end
endmodule
